// ===== hw/ppam_fifo.sv
`timescale 1ns/1ps
module ppam_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         mclk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  mem_q [DEPTH];
    logic [W-1:0]  mem_d [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rp_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        mem_d = mem_q;
        wp_d  = wp_q;
        rp_d  = rp_q;
        if (push) begin
            mem_d[wp_q] = in_data_i;
            wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
        end
        if (pop) begin
            rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
        end
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
        mem_q <= mem_d;
    end

    chk_fifo_no_overflow: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        cnt_q <= (AW+1)'(DEPTH)) else $error("Fifo count above depth.");
endmodule

// ===== hw/ppam_pkg.sv
package ppam_pkg;

    // ------------------------------------------------------------------
    // Mode and multiplex encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_LEGACY_SLV = 2'h0;
    localparam logic [1:0] MODE_ENH_SLV    = 2'h1;
    localparam logic [1:0] MODE_MASTER2    = 2'h2;
    localparam logic [1:0] MODE_MASTER1    = 2'h3;
    localparam logic [1:0] MUX_DEMUX       = 2'h0;
    localparam logic [1:0] MUX_PARTIAL     = 2'h1;
    localparam logic [1:0] MUX_FULL8       = 2'h2;
    localparam logic [1:0] MUX_FULL16      = 2'h3;
    localparam logic [1:0] INTERRUPT_MODE_SELECT_EVERY      = 2'h1;

    // ------------------------------------------------------------------
    // Pin positions and widths
    // ------------------------------------------------------------------
    localparam int PIN_LATCH_LOW  = 0;
    localparam int PIN_LATCH_HIGH = 1;
    localparam int PIN_CS1        = 14;
    localparam int PIN_CS2        = 15;
    localparam int PIN_W          = 16;
    localparam int BYTE_W         = 8;
    localparam int REQ_W          = 33;

    // ------------------------------------------------------------------
    // Timing and buffer depth
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int DATA_PHASE_NS = 30;
    localparam int DATA_CYCLES   = (DATA_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH    = 8;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR_LO,
        ST_ADDR_HI,
        ST_DATA
    } ppam_state_e;

endpackage

// ===== hw/ppam_port.sv
// Overview of operation
// (R1) Partial multiplex puts address low byte on data low byte, one extra cycle.
// (R2) Multiplex field 01: pin 0 is latch-low strobe, pins 7..1 released.
// (R3) Field 10: low address byte, then upper six or seven bits, two extra cycles.
// (R4) Field 11: whole address on 16-bit data bus in one extra cycle.
// (R5) Upper address part is seven bits without chip select, six with one.
// (R6) Full multiplex: pin 0 latch-low, pin 1 latch-high, pins 13..2 released.
// (R7) Far side latches the low address byte unless the peripheral does so.
// (R8) Mode 11 is master mode 1 with programmable active-high strobes.
// (R9) Mode 00 is legacy 8-bit slave selected by chip select one.
// (R10) In master mode the data input register carries transfer data for DMA.
// (R11) Interrupt mode 01 raises the interrupt after every transfer unit.
// (R12) Far side sets DMA start trigger to the port interrupt number.
// (R13) An address pin is driven only when its enable bit is one; the code also drives pins 14 and 15 when their chip select is enabled.
// (R14) Address pin 15 doubles as chip select two, pin 14 as chip select one.
// (R15) Without wide data only data pins 7..0 are used; the code also drives data pins 15..8 in the field 11 address cycle.
// (R16) Any slave mode claims chip select one, strobes and low data byte.
// (R17) Only enhanced slave uses address pins 1 and 0 as inputs.
// (R18) Slave modes use only the low data byte and ignore wide data.
// (R19) Demultiplexed mode drives address on address pins alongside data.
// (R20) Latch strobes pulse only during address phases, low in data phase.
`timescale 1ns/1ps
module ppam_port import ppam_pkg::*; #(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        port_enable_i,
    input  wire logic [1:0]  port_mode_i,
    input  wire logic [1:0]  address_multiplex_select_i,
    input  wire logic        wide_data_select_i,
    input  wire logic [1:0]  interrupt_mode_select_i,
    input  wire logic [15:0] address_pin_enable_register_i,
    input  wire logic        chip_select_one_enable_i,
    input  wire logic        chip_select_two_enable_i,
    input  wire logic        cs_active_high_i,
    input  wire logic        rd_active_high_i,
    input  wire logic        wr_active_high_i,
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire logic        req_write_i,
    input  wire logic [15:0] req_addr_i,
    input  wire logic [15:0] req_data_i,
    output logic [15:0]      data_input_register_o,
    output logic             data_valid_o,
    output logic [1:0]       slave_addr_o,
    input  wire logic [7:0]  slave_tx_i,
    output logic             irq_o,
    output logic             busy_o,
    input  wire logic [1:0]  port_address_pins_i,
    output logic [15:0]      port_address_pins_o,
    output logic [15:0]      port_address_pins_oe_n_o,
    output logic [15:0]      addr_pin_owned_o,
    input  wire logic [15:0] port_data_pins_i,
    output logic [15:0]      port_data_pins_o,
    output logic [15:0]      port_data_pins_oe_n_o,
    output logic [15:0]      data_pin_owned_o,
    input  wire logic        chip_select_one_pin_i,
    input  wire logic        read_strobe_pin_i,
    output logic             read_strobe_pin_o,
    output logic             read_strobe_pin_oe_n_o,
    input  wire logic        write_strobe_pin_i,
    output logic             write_strobe_pin_o,
    output logic             write_strobe_pin_oe_n_o
);
    // ------------------------------------------------------------------
    // Pin synchronisers and request buffer
    // ------------------------------------------------------------------
    localparam int SYNC_W = 21;

    logic [SYNC_W-1:0] sync1_q, sync2_q;
    logic [15:0]       s_data;
    logic [1:0]        s_addr;
    logic              s_cs, s_rd, s_wr;
    logic              f_valid, f_pop;
    logic [REQ_W-1:0]  f_data;

    assign {s_data, s_addr, s_cs, s_rd, s_wr} = sync2_q;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {port_data_pins_i, port_address_pins_i, chip_select_one_pin_i,
                        read_strobe_pin_i, write_strobe_pin_i};
            sync2_q <= sync1_q;
        end
    end

    // The buffer stalls the DMA source while the pins are slower than it.
    ppam_fifo #(.W(REQ_W), .DEPTH(DEPTH)) u_req_fifo (
        .mclk_i      (mclk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (req_valid_i),
        .in_ready_o  (req_ready_o),
        .in_data_i   ({req_write_i, req_addr_i, req_data_i}),
        .out_valid_o (f_valid),
        .out_ready_i (f_pop),
        .out_data_o  (f_data)
    );

    // ------------------------------------------------------------------
    // Transfer engine
    // ------------------------------------------------------------------
    ppam_state_e st_q, st_d;
    logic [1:0]  cnt_q, cnt_d;
    logic        wr_q, wr_d;
    logic [15:0] addr_q, addr_d, wdat_q, wdat_d, rdat_q, rdat_d;
    logic        dv_q, dv_d, irq_q, irq_d;
    logic [1:0]  saddr_q, saddr_d;
    logic        swsel_q, srsel_q;
    logic        master, slave, wide, done, cs_any, swsel, srsel, sw_end, sr_end;
    logic [1:0]  mux;
    logic [7:0]  upper;

    assign mux    = address_multiplex_select_i;
    assign master = port_enable_i && port_mode_i[1];
    assign slave  = port_enable_i && !port_mode_i[1];
    assign wide   = master && wide_data_select_i;                                   // [R15] [R18]
    assign cs_any = chip_select_one_enable_i || chip_select_two_enable_i;
    assign upper  = cs_any ? {2'h0, addr_q[13:8]} : {1'b0, addr_q[14:8]};           // [R5]
    assign swsel  = (s_cs == cs_active_high_i) && (s_wr == wr_active_high_i);       // [R9]
    assign srsel  = (s_cs == cs_active_high_i) && (s_rd == rd_active_high_i);
    assign sw_end = slave && swsel_q && !swsel;
    assign sr_end = slave && srsel_q && !srsel;
    assign done   = (st_q == ST_DATA) && (cnt_q == 2'(DATA_CYCLES - 1));

    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        wr_d    = wr_q;
        addr_d  = addr_q;
        wdat_d  = wdat_q;
        rdat_d  = rdat_q;
        saddr_d = saddr_q;
        f_pop   = 1'b0;
        dv_d    = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (master && f_valid) begin
                    f_pop  = 1'b1;
                    {wr_d, addr_d, wdat_d} = f_data;
                    cnt_d  = '0;
                    st_d   = (mux == MUX_DEMUX) ? ST_DATA : ST_ADDR_LO;             // [R19]
                end
            end
            ST_ADDR_LO: st_d = (mux == MUX_FULL8) ? ST_ADDR_HI : ST_DATA;           // [R1] [R3] [R4]
            ST_ADDR_HI: st_d = ST_DATA;                                             // [R3]
            ST_DATA: begin
                cnt_d = cnt_q + 2'h1;
                if (done) begin
                    st_d = ST_IDLE;
                    if (!wr_q) begin
                        rdat_d = wide ? s_data : {8'h0, s_data[7:0]};               // [R10]
                        dv_d   = 1'b1;
                    end
                end
            end
            default: st_d = ST_IDLE;
        endcase
        if (!master) begin
            st_d = ST_IDLE;
        end
        if (sw_end) begin
            rdat_d  = {8'h0, s_data[7:0]};                                          // [R18]
            dv_d    = 1'b1;
            saddr_d = (port_mode_i == MODE_ENH_SLV) ? s_addr : 2'h0;                // [R17]
        end
        irq_d = (interrupt_mode_select_i == INTERRUPT_MODE_SELECT_EVERY) && (done || sw_end || sr_end); // [R11]
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_q    <= ST_IDLE;
            cnt_q   <= '0;
            wr_q    <= 1'b0;
            addr_q  <= '0;
            wdat_q  <= '0;
            rdat_q  <= '0;
            saddr_q <= '0;
            dv_q    <= 1'b0;
            irq_q   <= 1'b0;
            swsel_q <= 1'b0;
            srsel_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            wr_q    <= wr_d;
            addr_q  <= addr_d;
            wdat_q  <= wdat_d;
            rdat_q  <= rdat_d;
            saddr_q <= saddr_d;
            dv_q    <= dv_d;
            irq_q   <= irq_d;
            swsel_q <= swsel;
            srsel_q <= srsel;
        end
    end

    assign data_input_register_o = rdat_q;
    assign data_valid_o          = dv_q;
    assign irq_o                 = irq_q;
    assign slave_addr_o          = saddr_q;
    assign busy_o                = (st_q != ST_IDLE);

    // ------------------------------------------------------------------
    // Pin map
    // ------------------------------------------------------------------
    logic [15:0] usable, a_own;
    logic        act, lat_lo, lat_hi, in_data;

    assign act     = (st_q != ST_IDLE);
    assign in_data = (st_q == ST_DATA);
    assign lat_lo  = (st_q == ST_ADDR_LO);                                          // [R20]
    assign lat_hi  = (st_q == ST_ADDR_HI) || (lat_lo && mux == MUX_FULL16);          // [R20]

    always_comb begin
        case (mux)
            MUX_DEMUX:   usable = 16'hffff;                                         // [R19]
            MUX_PARTIAL: usable = 16'hff01;                                         // [R2]
            default:     usable = 16'hc003;                                         // [R6]
        endcase
        a_own = address_pin_enable_register_i & usable;                             // [R13]
        a_own[PIN_CS1] = a_own[PIN_CS1] || chip_select_one_enable_i;                // [R14]
        a_own[PIN_CS2] = a_own[PIN_CS2] || chip_select_two_enable_i;                // [R14]

        port_address_pins_o      = '0;
        port_address_pins_oe_n_o = 16'hffff;
        addr_pin_owned_o         = '0;
        port_data_pins_o         = '0;
        port_data_pins_oe_n_o    = 16'hffff;
        data_pin_owned_o         = '0;
        read_strobe_pin_o        = 1'b0;
        read_strobe_pin_oe_n_o   = 1'b1;
        write_strobe_pin_o       = 1'b0;
        write_strobe_pin_oe_n_o  = 1'b1;

        if (master) begin
            addr_pin_owned_o         = a_own;
            port_address_pins_oe_n_o = ~a_own;
            port_address_pins_o      = addr_q;
            if (mux != MUX_DEMUX) begin
                port_address_pins_o[PIN_LATCH_LOW] = lat_lo;                        // [R2] [R6]
            end
            if (mux[1]) begin
                port_address_pins_o[PIN_LATCH_HIGH] = lat_hi;                       // [R6]
            end
            if (chip_select_one_enable_i) begin
                port_address_pins_o[PIN_CS1] = ~(act ^ cs_active_high_i);
            end
            if (chip_select_two_enable_i) begin
                port_address_pins_o[PIN_CS2] = ~(act ^ cs_active_high_i);
            end
            port_address_pins_o = port_address_pins_o & a_own;

            data_pin_owned_o = wide ? 16'hffff : 16'h00ff;                          // [R15]
            if (lat_lo) begin
                port_data_pins_o = {upper, addr_q[7:0]};                            // [R1] [R4]
                port_data_pins_oe_n_o = (mux == MUX_FULL16) ? 16'h0000 : 16'hff00;  // [R4]
            end else if (st_q == ST_ADDR_HI) begin
                port_data_pins_o      = {8'h0, upper};                              // [R3]
                port_data_pins_oe_n_o = 16'hff00;
            end else if (in_data && wr_q) begin
                port_data_pins_o      = wdat_q & data_pin_owned_o;
                port_data_pins_oe_n_o = ~data_pin_owned_o;
            end

            read_strobe_pin_oe_n_o  = 1'b0;
            write_strobe_pin_oe_n_o = 1'b0;
            if (port_mode_i == MODE_MASTER1) begin
                // Read/write level plus enable strobe; the level parks at read.
                read_strobe_pin_o  = ~((!wr_q || !act) ^ rd_active_high_i);         // [R8]
                write_strobe_pin_o = ~(in_data ^ wr_active_high_i);                 // [R8]
            end else begin
                read_strobe_pin_o  = ~((in_data && !wr_q) ^ rd_active_high_i);
                write_strobe_pin_o = ~((in_data && wr_q) ^ wr_active_high_i);
            end
        end else if (slave) begin
            addr_pin_owned_o[PIN_CS1] = 1'b1;                                       // [R16]
            if (port_mode_i == MODE_ENH_SLV) begin
                addr_pin_owned_o[1:0] = 2'h3;                                       // [R17]
            end
            data_pin_owned_o = 16'h00ff;                                            // [R16] [R18]
            if (srsel) begin
                port_data_pins_o      = {8'h0, slave_tx_i};
                port_data_pins_oe_n_o = 16'hff00;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_partial_one_cycle: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R1]
        (st_q == ST_ADDR_LO && mux == MUX_PARTIAL && master) |=> (st_q == ST_DATA))
        else $error("Partial multiplex took more than one address cycle.");

    chk_latch_low_pin: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R2]
        (master && mux == MUX_PARTIAL && lat_lo && address_pin_enable_register_i[0])
        |-> (port_address_pins_o[0] && !port_address_pins_oe_n_o[0]
             && addr_pin_owned_o[7:1] == 7'h0))
        else $error("Partial mode latch-low pin wrong.");

    chk_full8_two_cycles: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R3]
        (st_q == ST_ADDR_LO && mux == MUX_FULL8 && master)
        |=> (st_q == ST_ADDR_HI) ##1 (st_q == ST_DATA))
        else $error("Full 8-bit multiplex sequence wrong.");

    chk_full16_single: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R4]
        (st_q == ST_ADDR_LO && mux == MUX_FULL16 && master)
        |-> (port_data_pins_oe_n_o == 16'h0 && port_data_pins_o[7:0] == addr_q[7:0])
            ##1 (st_q == ST_DATA))
        else $error("Full 16-bit address phase wrong.");

    chk_upper_width: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R5]
        (st_q == ST_ADDR_HI && cs_any) |-> (port_data_pins_o[7:6] == 2'h0))
        else $error("Upper address part too wide with chip select.");

    chk_full_release: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R6]
        (master && mux[1]) |-> (addr_pin_owned_o[13:2] == 12'h0))
        else $error("Full multiplex claimed released pins.");

    chk_pin_enable: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R13]
        master |-> (&(port_address_pins_oe_n_o[13:0] | address_pin_enable_register_i[13:0])))
        else $error("Disabled address pin driven.");

    chk_slave_low_byte: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R18]
        slave |-> (&port_data_pins_oe_n_o[15:8] && data_pin_owned_o == 16'h00ff))
        else $error("Slave mode used upper data byte.");

    chk_latch_data_low: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R20]
        (master && mux != MUX_DEMUX && $past(lat_lo) && st_q == ST_DATA)
        |-> (port_address_pins_o[1:0] == 2'h0))
        else $error("Latch strobe still active in data phase.");

    chk_irq_follows_done: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R11]
        (done && interrupt_mode_select_i == INTERRUPT_MODE_SELECT_EVERY && master) |=> irq_o)
        else $error("No interrupt after master transfer.");
endmodule

// ===== verif/ppam_mem_model.sv
`timescale 1ns/1ps
module ppam_mem_model (
    input  wire logic        mclk_i,
    input  wire logic [1:0]  mode_i,
    input  wire logic [1:0]  mux_i,
    input  wire logic [15:0] apin_i,
    input  wire logic [15:0] dpin_i,
    input  wire logic        rd_pin_i,
    input  wire logic        wr_pin_i,
    output logic [15:0]      dq_o,
    output logic [7:0]       lo_o,
    output logic [7:0]       hi_o
);
    logic [15:0] mem [256];
    logic [15:0] last_q = 16'h5a5a;
    logic        rd_on;
    logic        wr_on;
    logic [7:0]  idx;
    // Master 1 uses the read pin as a direction level and the write pin as the enable.
    assign rd_on = (mode_i == 2'h3) ? (wr_pin_i & rd_pin_i) : rd_pin_i;
    assign wr_on = (mode_i == 2'h3) ? (wr_pin_i & ~rd_pin_i) : wr_pin_i;
    assign idx   = (mux_i == 2'h0) ? apin_i[7:0] : lo_o;
    // A released bus shows the inverse of the last value, so a stale copy never passes.
    assign dq_o  = rd_on ? mem[idx] : ~last_q;
    always @(posedge mclk_i) begin
        if (apin_i[0] && mux_i != 2'h0) lo_o <= dpin_i[7:0];
        if (apin_i[1] && mux_i[1]) hi_o <= mux_i[0] ? dpin_i[15:8] : dpin_i[7:0];
        if (wr_on) mem[idx] <= dpin_i;
        last_q <= dq_o;
    end
endmodule

// ===== verif/tb_parallel_port_addr_mux_pinmap.sv
`timescale 1ns/1ps
module tb_parallel_port_addr_mux_pinmap import ppam_pkg::*; ;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
    logic        clk = 0, rst = 1, en = 0, vld = 0, wr = 0, wide = 1, stall;
    logic        cs1e = 0, cs2e = 0, csp = 1, rdp = 1, wrp = 1, csi = 0, rdi = 0, wri = 0;
    logic [1:0]  mode = 2'h2, mux = 2'h0, interrupt_mode_select = 2'h0, api = 2'h0, saddr;
    logic [15:0] pen = 16'hffff, addr = 0, dat = 0, tbdq = 0, a, d, got, wv [20];
    logic [15:0] din, apo, aoe, aown, dpo, doe, down, memdq, dq;
    logic [7:0]  stx = 0, lo, hi;
    logic        rdy, dv, irq, busy, rdo, rdoe, wro, wroe;
    int          err_count = 0, total_checks = 0, nirq = 0, bcnt = 0, b0, i0, n;
    logic [15:0] rq [$];
    always #5 clk = ~clk;
    assign dq = (~doe & dpo) | (doe & (mode[1] ? memdq : tbdq));
    ppam_port ppam_port_i (.mclk_i(clk), .sys_rst_i(rst), .port_enable_i(en), .port_mode_i(mode),
        .address_multiplex_select_i(mux), .wide_data_select_i(wide),
        .interrupt_mode_select_i(interrupt_mode_select), .address_pin_enable_register_i(pen),
        .chip_select_one_enable_i(cs1e), .chip_select_two_enable_i(cs2e),
        .cs_active_high_i(csp), .rd_active_high_i(rdp), .wr_active_high_i(wrp),
        .req_valid_i(vld), .req_ready_o(rdy), .req_write_i(wr), .req_addr_i(addr),
        .req_data_i(dat), .data_input_register_o(din), .data_valid_o(dv),
        .slave_addr_o(saddr), .slave_tx_i(stx), .irq_o(irq), .busy_o(busy),
        .port_address_pins_i(api), .port_address_pins_o(apo), .port_address_pins_oe_n_o(aoe),
        .addr_pin_owned_o(aown), .port_data_pins_i(dq), .port_data_pins_o(dpo),
        .port_data_pins_oe_n_o(doe), .data_pin_owned_o(down), .chip_select_one_pin_i(csi),
        .read_strobe_pin_i(rdi), .read_strobe_pin_o(rdo), .read_strobe_pin_oe_n_o(rdoe),
        .write_strobe_pin_i(wri), .write_strobe_pin_o(wro), .write_strobe_pin_oe_n_o(wroe));
    ppam_mem_model ppam_mem_model_i (.mclk_i(clk), .mode_i(mode), .mux_i(mux), .apin_i(apo),
        .dpin_i(dq), .rd_pin_i(rdo), .wr_pin_i(wro), .dq_o(memdq), .lo_o(lo), .hi_o(hi));
    always @(posedge clk) begin
        if (dv === 1'b1) rq.push_back(din);
        if (irq === 1'b1) nirq++;
        if (busy === 1'b1) bcnt++;
    end
    function automatic int xtra(input logic [1:0] x);
        return (x == 2'h0) ? 0 : ((x == 2'h2) ? 2 : 1);
    endfunction
    function automatic logic [6:0] hm(input logic cs);
        // The top address bit is lost to a chip select whenever one is enabled.
        return (cs | cs2e) ? 7'h3f : 7'h7f;
    endfunction
    function automatic logic [15:0] own(input logic [1:0] x);
        return (x == 2'h0) ? 16'hffff : ((x == 2'h1) ? 16'hff01 : 16'hc003);
    endfunction
    task automatic push(input logic w, input logic [15:0] pa, pd);
        int k;
        @(negedge clk);
        vld = 1;
        wr = w;
        addr = pa;
        dat = pd;
        stall = (rdy !== 1'b1);
        k = 0;
        do @(posedge clk); while (rdy !== 1'b1 && ++k < 50);
        if (rdy !== 1'b1) err_count++;
    endtask
    task automatic idle();
        int q, k;
        @(negedge clk);
        vld = 0;
        q = 0;
        k = 0;
        while (q < 6 && k < 300) begin
            @(negedge clk);
            q = (busy === 1'b0) ? q + 1 : 0;
            k++;
        end
        if (q < 6) err_count++;
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        complete_run();
    end
    initial begin
        void'($urandom(45));
        repeat (10) @(negedge clk);
        rst = 0;
        `CHK("busy", 1'b0, busy)
        `CHK("data oe_n", 16'hffff, doe)
        en = 1;
        // -----------------------------------------------------------
        // Master modes across every multiplex setting
        // -----------------------------------------------------------
        for (int m = 2; m < 4; m++) for (int x = 0; x < 4; x++) begin
            mode = 2'(m);
            mux = 2'(x);
            cs1e = 1'($urandom);
            cs2e = 1'($urandom);
            interrupt_mode_select = {1'b0, 1'($urandom)};
            a = 16'($urandom);
            d = 16'($urandom);
            b0 = bcnt;
            i0 = nirq;
            push(1, a, d);
            idle();
            `CHK("busy span", DATA_CYCLES + xtra(mux), bcnt - b0)
            if (x != 0) `CHK("low latch", a[7:0], lo)
            if (x > 1) `CHK("high latch", a[14:8] & hm(cs1e), hi[6:0] & hm(cs1e))
            `CHK("addr owned", own(mux), aown)
            push(0, a, 0);
            idle();
            `CHK("read back", d, rq.pop_back())
            `CHK("irq count", 2 * interrupt_mode_select[0], nirq - i0)
        end
        mode = 2'h2;
        mux = 2'h0;
        pen = 16'($urandom);
        #1 `CHK("pin enable", pen | {cs2e, cs1e, 14'h0}, aown)
        `CHK("pin oe_n", ~(pen | {cs2e, cs1e, 14'h0}), aoe)
        wide = 0;
        #1 `CHK("narrow data", 16'h00ff, down)
        // -----------------------------------------------------------
        // Request buffer filled until refused, then drained
        // -----------------------------------------------------------
        pen = 16'hffff;
        wide = 1;
        interrupt_mode_select = 2'h1;
        i0 = nirq;
        n = 0;
        do begin
            wv[n] = 16'($urandom);
            push(1, 16'h0040 + 16'(n), wv[n]);
            n++;
        end while (!stall && n < 20);
        idle();
        `CHK("buffer refused", 1'b1, stall)
        `CHK("irq per word", n, nirq - i0)
        rq.delete();
        for (int k = 0; k < n; k++) push(0, 16'h0040 + 16'(k), 0);
        idle();
        for (int k = 0; k < n; k++) `CHK("burst read", wv[k], rq.pop_front())
        // -----------------------------------------------------------
        // Legacy and enhanced slave with random strobe polarity
        // -----------------------------------------------------------
        for (int s = 0; s < 2; s++) begin
            // Polarity changes while disabled, so no false strobe end is seen.
            en = 0;
            mode = 2'(s);
            pen = 16'h0;
            csp = 1'($urandom);
            rdp = 1'($urandom);
            wrp = 1'($urandom);
            csi = ~csp;
            rdi = ~rdp;
            wri = ~wrp;
            i0 = nirq;
            d = 16'($urandom);
            repeat (3) @(negedge clk);
            en = 1;
            api = 2'($urandom);
            tbdq = d;
            csi = csp;
            wri = wrp;
            repeat (4) @(negedge clk);
            csi = ~csp;
            wri = ~wrp;
            // The far master holds its data one cycle past the write strobe.
            @(negedge clk);
            tbdq = ~d;
            idle();
            got = rq.pop_front();
            `CHK("slave byte", d[7:0], got[7:0])
            `CHK("slave addr", s ? api : 2'h0, saddr)
            `CHK("slave pins", 16'h00ff, down)
            `CHK("addr inputs", s ? 2'h3 : 2'h0, aown[1:0])
            `CHK("strobe inputs", 1'b1, rdoe & wroe)
            stx = 8'($urandom);
            csi = csp;
            rdi = rdp;
            repeat (4) @(negedge clk);
            `CHK("slave tx", stx, dpo[7:0])
            `CHK("slave drive", 8'h00, doe[7:0])
            csi = ~csp;
            rdi = ~rdp;
            idle();
            `CHK("slave irq", 2, nirq - i0)
        end
        complete_run();
    end
endmodule
